// >>> verilog/dtc_cfg.svh
/*
  Constants of the dual timer/counter: register addresses, bit
  positions, reset values and machine-cycle lengths.
  Assumes it is included by its bare name from the design files.
*/
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// Register addresses on the special function register port
`define DTC_ADDR_CTRL_STATUS 8'h88
`define DTC_ADDR_MODE_CONFIG 8'h89
`define DTC_ADDR_LOW_ZERO    8'h8a
`define DTC_ADDR_LOW_ONE     8'h8b
`define DTC_ADDR_HIGH_ZERO   8'h8c
`define DTC_ADDR_HIGH_ONE    8'h8d

// Control/status bit positions
`define DTC_BIT_FLAG_ONE 7
`define DTC_BIT_RUN_ONE  6
`define DTC_BIT_FLAG_ZERO 5
`define DTC_BIT_RUN_ZERO 4

// Mode configuration bit positions
`define DTC_BIT_GATE_ONE 7
`define DTC_BIT_CSEL_ONE 6
`define DTC_BIT_MODE_ONE_HI 5
`define DTC_BIT_MODE_ONE_LO 4
`define DTC_BIT_GATE_ZERO 3
`define DTC_BIT_CSEL_ZERO 2
`define DTC_BIT_MODE_ZERO_HI 1
`define DTC_BIT_MODE_ZERO_LO 0

// Reset value shared by every register
`define DTC_RESET_BYTE 8'h00

// Oscillator clocks per machine cycle
`define DTC_CLKS_MC_12 4'hc
`define DTC_CLKS_MC_6  4'h6

`endif

// >>> verilog/dtc_pkg.sv
/*
  Types and the shared count-step function of the dual timer/counter.
  Assumes nothing of its surroundings.
*/
package dtc_pkg;

  // Counting modes, in mode-bit order
  typedef enum logic [1:0] {
    DTC_MODE_13,
    DTC_MODE_16,
    DTC_MODE_8R,
    DTC_MODE_SPLIT
  } dtc_mode_e;

  // One increment of a high/low pair: {overflow, high, low}
  function automatic logic [16:0] dtc_step(input dtc_mode_e m,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8  = {1'b0, lo} + 9'h001;
    case (m)
      DTC_MODE_13: dtc_step = {s13[13], s13[12:5], 3'h0, s13[4:0]};
      DTC_MODE_16: dtc_step = s16;
      DTC_MODE_8R: dtc_step = s8[8] ? {1'b1, hi, hi} : {1'b0, hi, s8[7:0]};
      default:     dtc_step = {s8[8], hi, s8[7:0]};
    endcase
  endfunction

endpackage

// >>> verilog/dtc_pin_sync.sv
/*
  Two-stage synchroniser for the event and gate pins, with a falling
  edge pulse taken from the synchronised samples.
  Assumes the pins are slow against ref_clk.
*/
module dtc_pin_sync #(
  parameter int W = 4
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pins_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_q;   // First stage, read only by second
  logic [W-1:0] sync_q;   // Second stage, the usable level
  logic [W-1:0] prev_q;   // Previous usable sample

  // Reset to low keeps a pin idle-high from giving a false fall
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pins_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // High sample then low sample marks a falling edge
  assign level = sync_q;
  assign fall  = prev_q & ~sync_q;
endmodule

// >>> verilog/dtc_mcycle.sv
/*
  Machine-cycle divider: one-cycle enable every 12 or 6 clocks.
  Assumes the 6-clock select is static while the timers run.
*/
`include "dtc_cfg.svh"
module dtc_mcycle (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic six_clk_mode,
  output logic      mc_tick
);
  logic [3:0] cnt_q;     // Clocks within the machine cycle
  logic [3:0] cnt_d;
  wire  [3:0] last_w;    // Final count of the cycle

  // Cycle length by operating mode
  assign last_w  = (six_clk_mode ? `DTC_CLKS_MC_6 : `DTC_CLKS_MC_12)
                   - 4'h1;
  // Compare with >= so a mode change can never skip the wrap
  assign mc_tick = (cnt_q >= last_w);
  assign cnt_d   = mc_tick ? 4'h0 : cnt_q + 4'h1;

  // Free-running divider
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// >>> verilog/dtc_timer.sv
/*
  Dual timer/counter with four modes behind the special function
  register port of the core: control/status, mode configuration and
  the four count bytes.
  Assumes the core drives one access per cycle on the register port,
  pulses an acknowledge when it services a unit's interrupt, and
  that the event and gate pins change slower than a machine cycle.
*/
`include "dtc_cfg.svh"
module dtc_timer (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       six_clk_mode,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       int_ack_zero,
  input  wire logic       int_ack_one,
  input  wire logic       event_pin_zero,
  input  wire logic       event_pin_one,
  input  wire logic       ext_gate_pin_zero,
  input  wire logic       ext_gate_pin_one,
  output logic            overflow_flag_zero,
  output logic            overflow_flag_one,
  output logic            baud_tick_one
);
  import dtc_pkg::*;

  // Register state
  logic [7:0] mode_cfg_q;    // Mode configuration
  logic       run0_q;        // Run bit, unit zero
  logic       run1_q;        // Run bit, unit one
  logic       flag0_q;       // Overflow flag, unit zero
  logic       flag1_q;       // Overflow flag, unit one
  logic [7:0] low0_q;        // Unit zero low count byte
  logic [7:0] high0_q;       // Unit zero high count byte
  logic [7:0] low1_q;        // Unit one low count byte
  logic [7:0] high1_q;       // Unit one high count byte
  logic [7:0] rdata_q;       // Registered read data
  logic       baud_q;        // Unit one overflow pulse
  logic [7:0] low0_d;        // Next values of the count bytes
  logic [7:0] high0_d;
  logic [7:0] low1_d;
  logic [7:0] high1_d;
  logic       flag0_d, flag1_d;

  // Synchronised pins: {gate1, gate0, event1, event0}
  wire  [3:0] pin_level;
  wire  [3:0] pin_fall;
  wire        mc_tick;       // One pulse per machine cycle

  // Pins come through two flops, so a level must stay for a
  // machine cycle to be seen
  dtc_pin_sync #(
    .W (4)
  ) i_dtc_pin_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pins_in ({ext_gate_pin_one, ext_gate_pin_zero,
               event_pin_one, event_pin_zero}),
    .level   (pin_level),
    .fall    (pin_fall)
  );

  // Machine-cycle enable
  dtc_mcycle i_dtc_mcycle (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .six_clk_mode (six_clk_mode),
    .mc_tick      (mc_tick)
  );

  // Mode configuration fields
  wire gate0 = mode_cfg_q[`DTC_BIT_GATE_ZERO];
  wire csel0 = mode_cfg_q[`DTC_BIT_CSEL_ZERO];
  wire gate1 = mode_cfg_q[`DTC_BIT_GATE_ONE];
  wire csel1 = mode_cfg_q[`DTC_BIT_CSEL_ONE];
  wire dtc_mode_e mode0 = dtc_mode_e'(
    mode_cfg_q[`DTC_BIT_MODE_ZERO_HI:`DTC_BIT_MODE_ZERO_LO]);
  wire dtc_mode_e mode1 = dtc_mode_e'(
    mode_cfg_q[`DTC_BIT_MODE_ONE_HI:`DTC_BIT_MODE_ONE_LO]);
  wire split0 = (mode0 == DTC_MODE_SPLIT);

  // Address decode
  wire wr_ctrl  = sfr_wr && (sfr_addr == `DTC_ADDR_CTRL_STATUS);
  wire wr_mode  = sfr_wr && (sfr_addr == `DTC_ADDR_MODE_CONFIG);
  wire wr_low0  = sfr_wr && (sfr_addr == `DTC_ADDR_LOW_ZERO);
  wire wr_low1  = sfr_wr && (sfr_addr == `DTC_ADDR_LOW_ONE);
  wire wr_high0 = sfr_wr && (sfr_addr == `DTC_ADDR_HIGH_ZERO);
  wire wr_high1 = sfr_wr && (sfr_addr == `DTC_ADDR_HIGH_ONE);
  wire wr_cnt   = wr_low0 || wr_low1 || wr_high0 || wr_high1;

  // Unit zero enable: run and gate, source by select
  wire en0   = run0_q && (!gate0 || pin_level[2]);
  wire tick0 = csel0 ? pin_fall[0] : mc_tick;
  wire inc0  = en0 && tick0;

  // Split high byte: machine cycles under unit one's run bit
  wire inc_hi = split0 && run1_q && mc_tick;

  // Unit one: split unit zero takes its run bit, own split stops it
  wire run1_eff = split0 || run1_q;
  wire en1   = run1_eff && (!gate1 || pin_level[3])
               && (mode1 != DTC_MODE_SPLIT);
  wire tick1 = csel1 ? pin_fall[1] : mc_tick;
  wire inc1  = en1 && tick1;

  // Increment results from the shared step function; the split high byte adds by itself
  wire [16:0] step0  = dtc_step(mode0, high0_q, low0_q);
  wire [16:0] step1  = dtc_step(mode1, high1_q, low1_q);
  wire [8:0]  hi_sum = {1'b0, high0_q} + 9'h001;

  // Overflow events
  wire ovf0_evt = inc0 && step0[16];
  wire ovf_hi   = inc_hi && hi_sum[8];
  wire ovf1_evt = inc1 && step1[16];
  // Unit one's flag follows the split high byte while split
  wire flag1_evt = split0 ? ovf_hi : ovf1_evt;

  // Helper views of the count pairs
  wire [15:0] cnt0_w = {high0_q, low0_q};
  wire [15:0] cnt1_w = {high1_q, low1_q};

  // Unit zero next count; a software write wins over counting
  always_comb begin
    low0_d  = low0_q;
    high0_d = high0_q;
    if (inc0) begin
      // Split mode moves the low byte only
      low0_d = step0[7:0];
      if (!split0) begin
        high0_d = step0[15:8];
      end
    end
    if (inc_hi) begin
      high0_d = hi_sum[7:0];
    end
    if (wr_low0) begin
      low0_d = sfr_wdata;
    end
    if (wr_high0) begin
      high0_d = sfr_wdata;
    end
  end

  // Unit one next count
  always_comb begin
    low1_d  = low1_q;
    high1_d = high1_q;
    if (inc1) begin
      low1_d  = step1[7:0];
      high1_d = step1[15:8];
    end
    if (wr_low1) begin
      low1_d = sfr_wdata;
    end
    if (wr_high1) begin
      high1_d = sfr_wdata;
    end
  end

  // Flags: hardware set beats software write and acknowledge
  always_comb begin
    flag0_d = flag0_q && !int_ack_zero;
    flag1_d = flag1_q && !int_ack_one;
    if (wr_ctrl) begin
      flag0_d = sfr_wdata[`DTC_BIT_FLAG_ZERO];
      flag1_d = sfr_wdata[`DTC_BIT_FLAG_ONE];
    end
    if (ovf0_evt) begin
      flag0_d = 1'b1;
    end
    if (flag1_evt) begin
      flag1_d = 1'b1;
    end
  end

  // Read mux; unmapped addresses and external-interrupt bits read 0
  wire [7:0] ctrl_view = {flag1_q, run1_q, flag0_q, run0_q, 4'h0};
  wire [7:0] rd_mux =
    (sfr_addr == `DTC_ADDR_CTRL_STATUS) ? ctrl_view :
    (sfr_addr == `DTC_ADDR_MODE_CONFIG) ? mode_cfg_q :
    (sfr_addr == `DTC_ADDR_LOW_ZERO)    ? low0_q :
    (sfr_addr == `DTC_ADDR_LOW_ONE)     ? low1_q :
    (sfr_addr == `DTC_ADDR_HIGH_ZERO)   ? high0_q :
    (sfr_addr == `DTC_ADDR_HIGH_ONE)    ? high1_q : 8'h00;

  // Configuration and run bits; run writes leave counts alone
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mode_cfg_q <= `DTC_RESET_BYTE;
      run0_q     <= 1'b0;
      run1_q     <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_cfg_q <= sfr_wdata;
      end
      if (wr_ctrl) begin
        run0_q <= sfr_wdata[`DTC_BIT_RUN_ZERO];
        run1_q <= sfr_wdata[`DTC_BIT_RUN_ONE];
      end
    end
  end

  // Count bytes and flags
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      low0_q  <= `DTC_RESET_BYTE;
      high0_q <= `DTC_RESET_BYTE;
      low1_q  <= `DTC_RESET_BYTE;
      high1_q <= `DTC_RESET_BYTE;
      flag0_q <= 1'b0;
      flag1_q <= 1'b0;
    end else begin
      low0_q  <= low0_d;
      high0_q <= high0_d;
      low1_q  <= low1_d;
      high1_q <= high1_d;
      flag0_q <= flag0_d;
      flag1_q <= flag1_d;
    end
  end

  // Read data and the baud pulse come from flops
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata_q <= 8'h00;
      baud_q  <= 1'b0;
    end else begin
      rdata_q <= rd_mux;
      baud_q  <= ovf1_evt;
    end
  end

  // Outputs
  assign sfr_rdata          = rdata_q;
  assign overflow_flag_zero = flag0_q;
  assign overflow_flag_one  = flag1_q;
  assign baud_tick_one      = baud_q;

  // Timer in 16-bit mode advances by one on an enabled cycle
  property p_timer16_step;
    @(posedge ref_clk) disable iff (!rstn)
    (run0_q && !gate0 && !csel0 && mode0 == DTC_MODE_16 && mc_tick
     && !wr_cnt && !wr_mode) |=> (cnt0_w == $past(cnt0_w) + 16'h0001);
  endproperty
  a_timer16_step: assert property (p_timer16_step)
    else $error("16-bit timer did not advance by one");

  // Machine cycle ticks are 6 or more clocks apart
  property p_mc_gap;
    @(posedge ref_clk) disable iff (!rstn)
    mc_tick |=> !mc_tick [*5];
  endproperty
  a_mc_gap: assert property (p_mc_gap)
    else $error("machine cycle shorter than six clocks");

  // Run bit cleared: count holds
  property p_stopped;
    @(posedge ref_clk) disable iff (!rstn)
    (!run0_q && !split0 && !wr_cnt) |=> $stable(cnt0_w);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("unit zero counted with run bit clear");

  // Gate set and gate pin low: count holds
  property p_gated;
    @(posedge ref_clk) disable iff (!rstn)
    (gate0 && !pin_level[2] && !split0 && !wr_cnt) |=> $stable(cnt0_w);
  endproperty
  a_gated: assert property (p_gated)
    else $error("unit zero counted with gate pin low");

  // Counter mode without a falling edge: count holds
  property p_no_edge;
    @(posedge ref_clk) disable iff (!rstn)
    (csel0 && !pin_fall[0] && !split0 && !wr_cnt) |=> $stable(cnt0_w);
  endproperty
  a_no_edge: assert property (p_no_edge)
    else $error("counter advanced without an event edge");

  // Rollover of the 16-bit count wraps and raises the flag
  property p_ovf16;
    @(posedge ref_clk) disable iff (!rstn)
    (inc0 && mode0 == DTC_MODE_16 && cnt0_w == 16'hffff && !wr_cnt
     && !wr_ctrl) |=> (flag0_q && cnt0_w == 16'h0000);
  endproperty
  a_ovf16: assert property (p_ovf16)
    else $error("rollover did not set overflow flag");

  // Reload mode copies the high byte into the low byte
  property p_reload;
    @(posedge ref_clk) disable iff (!rstn)
    (inc0 && mode0 == DTC_MODE_8R && low0_q == 8'hff && !wr_cnt)
    |=> (low0_q == $past(high0_q) && $stable(high0_q) && flag0_q);
  endproperty
  a_reload: assert property (p_reload)
    else $error("auto-reload did not copy high byte");

  // 13-bit counting holds the upper low-byte bits at zero
  property p_m13_upper;
    @(posedge ref_clk) disable iff (!rstn)
    (inc0 && mode0 == DTC_MODE_13 && !wr_cnt) |=> (low0_q[7:5] == 3'h0);
  endproperty
  a_m13_upper: assert property (p_m13_upper)
    else $error("13-bit mode left upper low bits set");

  // Unit one in split mode holds its count
  property p_split1_frozen;
    @(posedge ref_clk) disable iff (!rstn)
    (mode1 == DTC_MODE_SPLIT && !wr_cnt) |=> $stable(cnt1_w);
  endproperty
  a_split1_frozen: assert property (p_split1_frozen)
    else $error("unit one counted in its split mode");

  // Acknowledge clears the flag when no new overflow arrives
  property p_ack_clear;
    @(posedge ref_clk) disable iff (!rstn)
    (int_ack_zero && !ovf0_evt && !wr_ctrl) |=> !flag0_q;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("acknowledge did not clear flag zero");

endmodule

// >>> tb/dtc_pin_model.sv
/*
  Far-side model of the event and gate pins of the timer block.
  Assumes fire requests are one-cycle pulses from the bench.
*/
module dtc_pin_model (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic [1:0] fire,
  input  wire logic [1:0] gate,
  output logic      [1:0] event_pins,
  output logic      [1:0] gate_pins,
  output logic      [1:0] busy
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 12; // Slowest machine cycle, in clocks
  for (genvar u = 0; u < 2; u++) begin : g_unit
    logic [4:0] cnt_q; // Cycles left in the current pulse
    // Low for one machine cycle, then high as long again
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        cnt_q <= 5'h00;
      end else if (fire[u] && cnt_q == 5'h00) begin
        cnt_q <= 5'(2 * HOLD);
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
    // Idle high, so a fall is always seen after a high level
    assign event_pins[u] = !(cnt_q > 5'(HOLD));
    assign busy[u]       = cnt_q != 5'h00;
  end
  // Gate pins follow the bench one cycle late, like a slow source
  always_ff @(posedge ref_clk) begin
    gate_pins <= gate;
  end
endmodule

// >>> tb/dtc_timer_test.sv
/*
  Self-checking bench of the dual timer/counter.
  Assumes the register port contract of the block and the pin model.
*/
`include "dtc_cfg.svh"
module dtc_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk;
  logic       rstn;
  logic       six_clk_mode;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       int_ack_zero;
  logic       int_ack_one;
  logic [1:0] fire;
  logic [1:0] gate;
  logic [1:0] event_pins;
  logic [1:0] gate_pins;
  logic [1:0] busy;
  logic       overflow_flag_zero;
  logic       overflow_flag_one;
  logic       baud_tick_one;
  int         fails;
  int         comparisons;
  int         cycles;
  logic [7:0] rv;

  dtc_timer i_dtc_timer (.ref_clk(ref_clk), .rstn(rstn),
    .six_clk_mode(six_clk_mode), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .int_ack_zero(int_ack_zero), .int_ack_one(int_ack_one),
    .event_pin_zero(event_pins[0]), .event_pin_one(event_pins[1]),
    .ext_gate_pin_zero(gate_pins[0]), .ext_gate_pin_one(gate_pins[1]),
    .overflow_flag_zero(overflow_flag_zero),
    .overflow_flag_one(overflow_flag_one), .baud_tick_one(baud_tick_one));
  dtc_pin_model i_dtc_pin_model (.ref_clk(ref_clk), .rstn(rstn),
    .fire(fire), .gate(gate), .event_pins(event_pins),
    .gate_pins(gate_pins), .busy(busy));

  // Free-running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Hang guard: whole run needs well under this many cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus tasks start and end at a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    // Idle cycle, so a following write never retoggles the strobe
    @(negedge ref_clk);
  endtask
  // Read data is registered: one cycle after the address
  task automatic peek(input logic [7:0] a);
    sfr_addr = a;
    @(negedge ref_clk);
    rv = sfr_rdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    peek(a);
    check(rv, exp);
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0:       return overflow_flag_zero;
      1:       return overflow_flag_one;
      default: return baud_tick_one;
    endcase
  endfunction
  // Bounded wait for a flag or pulse, then judged
  task automatic wait_for(input int sel, input int limit);
    int n;
    n = 0;
    while (n < limit && pick(sel) !== 1'b1) begin
      @(negedge ref_clk);
      n++;
    end
    check({7'h00, pick(sel)}, 8'h01);
  endtask
  // Falling edges on one event pin, each fully spaced
  task automatic pulse(input int u, input int n);
    repeat (n) begin
      fire[u] = 1'b1;
      @(negedge ref_clk);
      fire[u] = 1'b0;
      while (busy[u] !== 1'b0) @(negedge ref_clk);
    end
  endtask
  task automatic do_reset;
    rstn = 1'b0;
    repeat (8) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
  endtask

  // Reset values, unmapped address, read-only low control bits
  task automatic t_reset;
    for (int a = 'h88; a <= 'h8e; a++) rd(8'(a), 8'h00);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h0f);
    rd(`DTC_ADDR_CTRL_STATUS, 8'h00);
    wr(`DTC_ADDR_MODE_CONFIG, 8'ha5);
    rd(`DTC_ADDR_MODE_CONFIG, 8'ha5);
    $display("reset test done");
  endtask
  // Runs one unit-zero timer preset to overflow, then stops it
  task automatic t_over(input logic [7:0] md, input logic [7:0] hi,
                        input logic [7:0] lo, input logic [7:0] ehi,
                        input logic [7:0] elo);
    wr(`DTC_ADDR_MODE_CONFIG, md);
    wr(`DTC_ADDR_LOW_ZERO, lo);
    wr(`DTC_ADDR_HIGH_ZERO, hi);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h10);
    wait_for(0, 30);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h20);
    rd(`DTC_ADDR_LOW_ZERO, elo);
    rd(`DTC_ADDR_HIGH_ZERO, ehi);
    int_ack_zero = 1'b1;
    @(negedge ref_clk);
    int_ack_zero = 1'b0;
    rd(`DTC_ADDR_CTRL_STATUS, 8'h00);
    $display("overflow test mode %h done", md);
  endtask
  // Machine cycles counted over a fixed 120-clock span
  task automatic t_rate(input logic [7:0] exp);
    logic [7:0] first;
    wr(`DTC_ADDR_MODE_CONFIG, 8'h01);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h10);
    peek(`DTC_ADDR_LOW_ZERO);
    first = rv;
    repeat (119) @(negedge ref_clk);
    peek(`DTC_ADDR_LOW_ZERO);
    check(rv - first, exp);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h00);
    $display("rate test done");
  endtask
  // Event counting with gate, stop and restart
  task automatic t_counter;
    wr(`DTC_ADDR_MODE_CONFIG, 8'h0d);
    wr(`DTC_ADDR_LOW_ZERO, 8'h00);
    wr(`DTC_ADDR_HIGH_ZERO, 8'h00);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h10);
    pulse(0, 2);
    rd(`DTC_ADDR_LOW_ZERO, 8'h00);
    gate[0] = 1'b1;
    repeat (4) @(negedge ref_clk);
    pulse(0, 3);
    rd(`DTC_ADDR_LOW_ZERO, 8'h03);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h00);
    pulse(0, 1);
    rd(`DTC_ADDR_LOW_ZERO, 8'h03);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h10);
    pulse(0, 1);
    rd(`DTC_ADDR_LOW_ZERO, 8'h04);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h00);
    gate[0] = 1'b0;
    $display("counter test done");
  endtask
  // Split unit zero: high byte on unit one controls and flag
  task automatic t_split;
    wr(`DTC_ADDR_MODE_CONFIG, 8'h03);
    wr(`DTC_ADDR_LOW_ZERO, 8'h00);
    wr(`DTC_ADDR_HIGH_ZERO, 8'hff);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h40);
    wait_for(1, 30);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h80);
    rd(`DTC_ADDR_LOW_ZERO, 8'h00);
    int_ack_one = 1'b1;
    @(negedge ref_clk);
    int_ack_one = 1'b0;
    rd(`DTC_ADDR_CTRL_STATUS, 8'h00);
    // Unit one still runs as a rate source, without a flag
    wr(`DTC_ADDR_MODE_CONFIG, 8'h23);
    wr(`DTC_ADDR_HIGH_ONE, 8'hf0);
    wr(`DTC_ADDR_LOW_ONE, 8'hfe);
    wait_for(2, 30);
    check({7'h00, overflow_flag_one}, 8'h00);
    // Unit one in its own split mode holds its count
    wr(`DTC_ADDR_MODE_CONFIG, 8'h30);
    wr(`DTC_ADDR_LOW_ONE, 8'h05);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h40);
    repeat (60) @(negedge ref_clk);
    rd(`DTC_ADDR_LOW_ONE, 8'h05);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h00);
    $display("split test done");
  endtask

  // Unit one as a gated event counter
  task automatic t_unit_one;
    wr(`DTC_ADDR_MODE_CONFIG, 8'hd1);
    wr(`DTC_ADDR_LOW_ONE, 8'h00);
    wr(`DTC_ADDR_HIGH_ONE, 8'h00);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h40);
    pulse(1, 1);
    rd(`DTC_ADDR_LOW_ONE, 8'h00);
    gate[1] = 1'b1;
    repeat (4) @(negedge ref_clk);
    pulse(1, 2);
    rd(`DTC_ADDR_LOW_ONE, 8'h02);
    wr(`DTC_ADDR_CTRL_STATUS, 8'h00);
    gate[1] = 1'b0;
    $display("unit one counter test done");
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    six_clk_mode = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    int_ack_zero = 1'b0;
    int_ack_one = 1'b0;
    fire = 2'b00;
    gate = 2'b00;
    fails = 0;
    comparisons = 0;
    cycles = 0;
    @(negedge ref_clk);
    do_reset();
    t_reset();
    t_over(8'h00, 8'hff, 8'hfe, 8'h00, 8'h00);
    t_over(8'h01, 8'hff, 8'hfe, 8'h00, 8'h00);
    t_over(8'h02, 8'h80, 8'hff, 8'h80, 8'h80);
    t_rate(8'h0a);
    t_counter();
    t_split();
    t_unit_one();
    six_clk_mode = 1'b1;
    do_reset();
    t_rate(8'h14);
    test_done();
  end
endmodule
